// *** rtl/mbpl_pkg.sv ***
/*
  Shared constants and state types for the bank side of the packet link.
  Assumes every party of the link runs on the one system clock.
*/
package mbpl_pkg;
  // Word layout
  localparam int DATA_W = 64;
  localparam int CHECK_W = 8;
  localparam int WORD_W = DATA_W + CHECK_W;
  // Data link packets
  localparam int PKT_W = 18;
  localparam int PKTS_PER_WORD = 4;
  localparam int PCNT_W = 3;
  localparam logic [PCNT_W-1:0] PCNT_LAST = 3'h3;
  // Address link packets
  localparam int APKT_W = 12;
  localparam int APKTS = 2;
  localparam int BANK_ADDR_W = APKT_W * APKTS;
  // System organisation
  localparam int NUM_BANKS = 512;
  localparam int BANK_WORDS_W = 22;
  localparam int NUM_PROC = 16;
  // Read request queue
  localparam int RQ_DEPTH = 8;
  // Engine states
  typedef enum logic [1:0] {W_IDLE, W_ADDR, W_DATA} mbpl_wr_state_type;
  typedef enum logic {R_IDLE, R_SEND} mbpl_rd_state_type;
endpackage : mbpl_pkg

// *** rtl/mbpl_bank.sv ***
/*
  Bank end of the packetised memory link: write assembly, read request
  queue, read-out streamer, and the word store of one bank.
  Assumes the access ports are logic on the same clock, send check bits
  already generated, and wait for the ready levels before starting.
*/
// Functional notes
// - Stored words are 72 bits, data plus check.
// - Data links move one 18-bit packet per clock.
// - One word takes four consecutive packet clocks.
// - Read and write streams run independently, concurrently.
// - Addresses use separate 12-bit packet links.
// - Bank address is two packets over two clocks.
// - Bank stores words selected by in-bank address.
// - Bank serves read and write port per processor.
// - Port pair reads and writes words concurrently.
// - Both latch phases fold onto one edge.
`timescale 1ns/10ps
`default_nettype none

module mbpl_fifo #(
  parameter int W = 28,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Filling side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // Draining side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] cnt;
  } mbpl_fifo_type;

  mbpl_fifo_type q, d;
  logic push, pop;

  // Honest flags straight from the occupancy count
  assign in_ready = q.cnt != FULL;
  assign out_valid = q.cnt != '0;
  assign out_data = q.mem[q.rp];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Next state
  always_comb begin
    d = q;
    if (push) begin
      d.mem[q.wp] = in_data;
      d.wp = (q.wp == LAST) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == LAST) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + CW'(push) - CW'(pop);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  property p_fifo_bound;
    @(posedge clk) disable iff (!rst_n) q.cnt <= FULL;
  endproperty
  a_fifo_bound: assert property (p_fifo_bound) else $error("queue count exceeds depth");
endmodule : mbpl_fifo

module mbpl_bank
  import mbpl_pkg::*;
#(
  parameter int NP = NUM_PROC,
  parameter int STORE_AW = BANK_WORDS_W,
  parameter int QDEPTH = RQ_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Write address links, one per processor
  input wire logic [NP-1:0][APKT_W-1:0] wa_pkt,
  input wire logic [NP-1:0] wa_start,
  // Write data links, one per processor
  input wire logic [NP-1:0][PKT_W-1:0] wd_pkt,
  input wire logic [NP-1:0] wd_start,
  // Read address links, one per processor
  input wire logic [NP-1:0][APKT_W-1:0] ra_pkt,
  input wire logic [NP-1:0] ra_start,
  // Read data link, steered by one-hot destination
  output logic [PKT_W-1:0] rd_pkt,
  output logic rd_start,
  output logic rd_valid,
  output logic [NP-1:0] rd_dest,
  // Acceptance levels
  output logic wr_ready,
  output logic ra_ready
);
  localparam int PW = (NP > 1) ? $clog2(NP) : 1;
  localparam int RQ_W = PW + BANK_ADDR_W;

  typedef struct packed {
    mbpl_wr_state_type w_st;
    logic [PW-1:0] w_port;
    logic [BANK_ADDR_W-1:0] w_addr;
    logic [PCNT_W-1:0] w_dcnt;
    logic [WORD_W-1:0] w_word;
    logic ra_busy;
    logic [PW-1:0] ra_port;
    logic [APKT_W-1:0] ra_hi;
    mbpl_rd_state_type r_st;
    logic [PCNT_W-1:0] r_cnt;
    logic [WORD_W-1:0] r_word;
    logic [NP-1:0] r_dest;
    logic [PKT_W-1:0] rd_pkt;
    logic rd_start;
    logic rd_valid;
  } mbpl_bank_type;

  mbpl_bank_type q, d;

  // Word store of this bank; upper address bits beyond STORE_AW alias
  logic [WORD_W-1:0] store_q [2**STORE_AW];

  logic mem_we, w_first, w_step;
  logic [WORD_W-1:0] w_word_n;
  logic [PW-1:0] w_grab, r_grab;
  logic fq_in_ready, fq_out_valid, fq_out_ready, pop;
  logic [RQ_W-1:0] fq_in_data, fq_out_data;
  logic [WORD_W-1:0] rd_word_w;

  // Lowest requesting processor wins; fixed priority keeps it cheap
  function automatic logic [PW-1:0] pick_lowest(input logic [NP-1:0] v);
    logic [PW-1:0] idx;
    idx = '0;
    for (int i = NP - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = PW'(i);
      end
    end
    return idx;
  endfunction : pick_lowest

  assign w_grab = pick_lowest(wa_start);
  assign r_grab = pick_lowest(ra_start);

  // Read requests queue up so bursts of addresses are not lost
  mbpl_fifo #(.W(RQ_W), .DEPTH(QDEPTH)) u_rq (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(q.ra_busy),
    .in_ready(fq_in_ready),
    .in_data(fq_in_data),
    .out_valid(fq_out_valid),
    .out_ready(fq_out_ready),
    .out_data(fq_out_data)
  );

  assign fq_in_data = {q.ra_port, q.ra_hi, ra_pkt[q.ra_port]};
  // Drain stalls while a word is still streaming out
  assign fq_out_ready = (q.r_st == R_IDLE) || (q.r_cnt == PCNT_LAST);
  assign pop = fq_out_valid && fq_out_ready;
  assign rd_word_w = store_q[fq_out_data[STORE_AW-1:0]];

  // Data packets shift in from the granted port, first packet on top
  assign w_step = (q.w_st != W_IDLE) &&
                  ((q.w_dcnt == '0 && wd_start[q.w_port]) || (q.w_dcnt != '0));
  assign w_first = ((q.w_st == W_IDLE) && (|wa_start) && wd_start[w_grab]) ||
                   (w_step && q.w_dcnt == '0);
  assign w_word_n = {q.w_word[WORD_W-PKT_W-1:0], wd_pkt[q.w_port]};
  assign mem_we = (q.w_st == W_DATA) && w_step && (q.w_dcnt == PCNT_LAST);

  assign wr_ready = q.w_st == W_IDLE;
  assign ra_ready = !q.ra_busy && fq_in_ready;
  assign rd_pkt = q.rd_pkt;
  assign rd_start = q.rd_start;
  assign rd_valid = q.rd_valid;
  assign rd_dest = q.r_dest;

  // Next state of write engine, read address assembly and read streamer
  always_comb begin
    d = q;
    // Write engine: two address packets alongside four data packets
    case (q.w_st)
      W_IDLE: begin
        if (|wa_start) begin
          d.w_port = w_grab;
          d.w_addr = {wa_pkt[w_grab], {APKT_W{1'b0}}};
          d.w_st = W_ADDR;
          d.w_dcnt = '0;
          if (wd_start[w_grab]) begin
            d.w_word = {q.w_word[WORD_W-PKT_W-1:0], wd_pkt[w_grab]};
            d.w_dcnt = 3'h1;
          end
        end
      end
      W_ADDR: begin
        d.w_addr = {q.w_addr[BANK_ADDR_W-1:APKT_W], wa_pkt[q.w_port]};
        d.w_st = W_DATA;
        if (w_step) begin
          d.w_word = w_word_n;
          d.w_dcnt = q.w_dcnt + 3'h1;
        end
      end
      W_DATA: begin
        if (w_step) begin
          d.w_word = w_word_n;
          d.w_dcnt = q.w_dcnt + 3'h1;
        end
        if (mem_we) begin
          d.w_st = W_IDLE;
          d.w_dcnt = '0;
        end
      end
      default: begin
        d.w_st = W_IDLE;
      end
    endcase
    // Read address assembly runs beside the write engine
    if (q.ra_busy) begin
      d.ra_busy = 1'b0;
    end else if ((|ra_start) && fq_in_ready) begin
      d.ra_busy = 1'b1;
      d.ra_port = r_grab;
      d.ra_hi = ra_pkt[r_grab];
    end
    // Read streamer: a new word may follow the last packet directly
    d.rd_start = 1'b0;
    if (pop) begin
      d.rd_pkt = rd_word_w[WORD_W-1 -: PKT_W];
      d.r_word = {rd_word_w[WORD_W-PKT_W-1:0], {PKT_W{1'b0}}};
      d.rd_start = 1'b1;
      d.rd_valid = 1'b1;
      d.r_cnt = '0;
      d.r_st = R_SEND;
      d.r_dest = NP'(1) << fq_out_data[RQ_W-1 -: PW];
    end else begin
      case (q.r_st)
        R_IDLE: begin
          d.rd_valid = 1'b0;
        end
        R_SEND: begin
          if (q.r_cnt == PCNT_LAST) begin
            d.r_st = R_IDLE;
            d.rd_valid = 1'b0;
            d.rd_pkt = '0;
            d.r_dest = '0;
          end else begin
            d.rd_pkt = q.r_word[WORD_W-1 -: PKT_W];
            d.r_word = {q.r_word[WORD_W-PKT_W-1:0], {PKT_W{1'b0}}};
            d.r_cnt = q.r_cnt + 3'h1;
          end
        end
        default: begin
          d.r_st = R_IDLE;
        end
      endcase
    end
  end

  // Both latch phases are folded onto this single rising edge
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Full 72-bit word with its check bits lands in one store cycle
  always_ff @(posedge clk) begin
    if (mem_we) begin
      store_q[q.w_addr[STORE_AW-1:0]] <= w_word_n;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_rd_tail;
    (!rd_start && rd_valid) [*3];
  endsequence
  sequence s_wr_fill;
    ##3 mem_we;
  endsequence

  property p_rd_frame;
    rd_start |=> s_rd_tail;
  endproperty
  a_rd_frame: assert property (p_rd_frame) else $error("read group not four packets");
  property p_rd_dest;
    rd_start |=> $stable(rd_dest) [*3];
  endproperty
  a_rd_dest: assert property (p_rd_dest) else $error("read destination moved mid word");
  property p_wr_commit;
    w_first |-> s_wr_fill;
  endproperty
  a_wr_commit: assert property (p_wr_commit) else $error("write not stored after four packets");
  property p_ra_pair;
    (ra_ready && |ra_start) |=> (q.ra_busy && !ra_ready) ##1 !q.ra_busy;
  endproperty
  a_ra_pair: assert property (p_ra_pair) else $error("read address not two packets");
  property p_pop_start;
    pop |=> rd_start && rd_valid;
  endproperty
  a_pop_start: assert property (p_pop_start) else $error("dequeued read did not start");
  property p_rd_msb;
    pop |=> rd_pkt == $past(rd_word_w[WORD_W-1 -: PKT_W]);
  endproperty
  a_rd_msb: assert property (p_rd_msb) else $error("first packet not top slice");
  property p_wr_busy;
    mem_we |-> !wr_ready ##1 wr_ready;
  endproperty
  a_wr_busy: assert property (p_wr_busy) else $error("write ready wrong around store");
  property p_wr_addr;
    (wr_ready && |wa_start) |=> (q.w_st == W_ADDR) ##1 (q.w_st == W_DATA);
  endproperty
  a_wr_addr: assert property (p_wr_addr) else $error("write address not two packets");
endmodule : mbpl_bank

`default_nettype wire

// *** tb/mbpl_port_model.sv ***
/*
  Access port model for every processor: drives the write and read links.
  Assumes the bank ready levels and one shared clock; tasks are called
  just after a rising edge.
*/
`timescale 1ns/10ps
`default_nettype none
module mbpl_port_model
  import mbpl_pkg::*;
(
  // Clock and bank levels
  input wire logic clk,
  input wire logic wr_ready,
  input wire logic ra_ready,
  // Links towards the bank
  output logic [NUM_PROC-1:0][APKT_W-1:0] wa_pkt,
  output logic [NUM_PROC-1:0] wa_start,
  output logic [NUM_PROC-1:0][PKT_W-1:0] wd_pkt,
  output logic [NUM_PROC-1:0] wd_start,
  output logic [NUM_PROC-1:0][APKT_W-1:0] ra_pkt,
  output logic [NUM_PROC-1:0] ra_start
);
  // Idle links at time zero
  initial begin
    {wa_pkt, wa_start, wd_pkt, wd_start, ra_pkt, ra_start} = '0;
  end

  // Byte parity stands in for the check code; weak but opaque to the bank
  function automatic logic [CHECK_W-1:0] chk(input logic [DATA_W-1:0] d);
    for (int i = 0; i < CHECK_W; i++) chk[i] = ^d[i*8+:8];
  endfunction : chk

  // One word: data aligned with the address or lagging it by lag cycles, upper parts first
  task automatic wr(input int p, input logic [BANK_ADDR_W-1:0] a, input logic [WORD_W-1:0] w,
                    input int lag);
    while (wr_ready !== 1'b1) @(posedge clk) #1;
    wa_start[p] = 1'b1;
    for (int j = 0; j < lag + PKTS_PER_WORD; j++) begin
      wd_start[p] = (j == lag);
      if (j >= lag) wd_pkt[p] = w[WORD_W-1-(j-lag)*PKT_W-:PKT_W];
      if (j < APKTS) wa_pkt[p] = a[BANK_ADDR_W-1-j*APKT_W-:APKT_W];
      else if (j == APKTS) wa_pkt[p] = ~wa_pkt[p];
      @(posedge clk) #1;
      wa_start[p] = 1'b0;
    end
    wd_start[p] = 1'b0;
    wd_pkt[p] = ~wd_pkt[p];
    @(posedge clk) #1;
  endtask : wr

  // Read request: two address packets, then released
  task automatic rd(input int p, input logic [BANK_ADDR_W-1:0] a);
    while (ra_ready !== 1'b1) @(posedge clk) #1;
    ra_start[p] = 1'b1;
    ra_pkt[p] = a[23:12];
    @(posedge clk) #1;
    ra_start[p] = 1'b0;
    ra_pkt[p] = a[11:0];
    @(posedge clk) #1;
    ra_pkt[p] = ~ra_pkt[p];
    @(posedge clk) #1;
  endtask : rd
endmodule : mbpl_port_model
`default_nettype wire

// *** tb/memory_bank_packet_link_tb.sv ***
/*
  Self-checking bench for the bank end, with a small store.
  Assumes the port model drives all links; read words are checked in order.
*/
`timescale 1ns/10ps
`default_nettype none
module memory_bank_packet_link_tb;
  import mbpl_pkg::*;
  localparam int SAW = 8;
  logic clk, rst_n, rd_start, rd_valid, wr_ready, ra_ready, saw_full;
  logic [NUM_PROC-1:0][APKT_W-1:0] wa_pkt, ra_pkt;
  logic [NUM_PROC-1:0][PKT_W-1:0] wd_pkt;
  logic [NUM_PROC-1:0] wa_start, wd_start, ra_start, rd_dest, dst;
  logic [PKT_W-1:0] rd_pkt;
  logic [WORD_W-1:0] mem [2**SAW];
  logic [WORD_W-1:0] got;
  logic [WORD_W+NUM_PROC-1:0] e;
  logic [WORD_W+NUM_PROC-1:0] notes [$];
  int n_mismatch, compares, k, lows;

  mbpl_port_model i_mbpl_port_model (.clk(clk), .wr_ready(wr_ready), .ra_ready(ra_ready),
    .wa_pkt(wa_pkt), .wa_start(wa_start), .wd_pkt(wd_pkt), .wd_start(wd_start),
    .ra_pkt(ra_pkt), .ra_start(ra_start));
  mbpl_bank #(.STORE_AW(SAW)) i_mbpl_bank (.clk(clk), .rst_n(rst_n), .wa_pkt(wa_pkt),
    .wa_start(wa_start), .wd_pkt(wd_pkt), .wd_start(wd_start), .ra_pkt(ra_pkt),
    .ra_start(ra_start), .rd_pkt(rd_pkt), .rd_start(rd_start), .rd_valid(rd_valid),
    .rd_dest(rd_dest), .wr_ready(wr_ready), .ra_ready(ra_ready));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input logic [WORD_W+NUM_PROC-1:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : tally_and_finish

  // Store the word in the expected image, then send it; data lags its address by 0 to 2 cycles
  task automatic wr(input int p, input logic [7:0] lo);
    logic [DATA_W-1:0] d;
    d = {$urandom, $urandom};
    mem[lo] = {d, i_mbpl_port_model.chk(d)};
    i_mbpl_port_model.wr(p, {16'($urandom), lo}, mem[lo], p % 3);
  endtask : wr

  // Note the expected answer, then request; high bits vary to show aliasing
  task automatic rd(input int p, input logic [7:0] lo);
    notes.push_back({mem[lo], NUM_PROC'(1) << p});
    i_mbpl_port_model.rd(p, {16'($urandom), lo});
  endtask : rd

  // Watch the read link at the falling edge where everything is settled
  always @(negedge clk) begin
    lows = (ra_ready === 1'b0) ? lows + 1 : 0;
    if (lows > 1) saw_full = 1'b1;
    if (rd_start === 1'b1) begin
      k = 0;
      dst = rd_dest;
    end
    if (rd_valid === 1'b1 && k < PKTS_PER_WORD) begin
      got = {got[WORD_W-PKT_W-1:0], rd_pkt};
      k++;
      check(rd_dest, dst);
      if (k == PKTS_PER_WORD) begin
        e = notes.size() ? notes.pop_front() : '1;
        check({got, dst}, e);
        check(got[CHECK_W-1:0], i_mbpl_port_model.chk(got[WORD_W-1:CHECK_W]));
      end
    end
  end

  initial begin
    rst_n = 1'b0;
    {n_mismatch, compares, k, lows, saw_full} = '0;
    void'($urandom(47));
    repeat (8) @(posedge clk);
    #1 rst_n = 1'b1;
    check({rd_valid, rd_start, rd_dest, rd_pkt, wr_ready, ra_ready}, 2'b11);
    $display("test reset done");
    for (int p = 0; p < NUM_PROC; p++) wr(p, 8'(p));
    for (int p = 0; p < NUM_PROC; p++) rd(15 - p, 8'(p));
    $display("test write and read every processor done");
    fork
      for (int p = 0; p < NUM_PROC; p++) wr(p, 8'(p + 16));
      for (int p = 0; p < NUM_PROC; p++) rd(p, 8'(p));
    join
    $display("test concurrent streams done");
    for (int i = 0; i < 48; i++) rd(i % 16, 8'(i % 32));
    for (int i = 0; i < 400 && notes.size() > 0; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    #1 check({rd_valid, rd_dest, notes.size() == 0, saw_full}, 2'b11);
    $display("test queue fill and drain done");
    tally_and_finish;
  end

  // Hang guard
  initial begin
    #100000;
    n_mismatch++;
    $display("unexpected at %0t: run did not finish", $time);
    tally_and_finish;
  end
endmodule : memory_bank_packet_link_tb
`default_nettype wire
